// >>> design/srsm_pkg.sv
// Purpose: shared constants and types of the safety relay state machine
// Assumes: 40 MHz system clock
// Notes: cycle counts derive from the times in ms

package srsm_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned SWITCH_ON_MS = 2500;
	localparam int unsigned ACTIVATE_MS = 100;
	localparam int unsigned RESPONSE_MS = 20;
	localparam int unsigned TMR_W = 27;
	localparam logic [TMR_W-1:0] SWITCH_ON_CYC = TMR_W'(SWITCH_ON_MS * CYC_PER_MS);
	localparam logic [TMR_W-1:0] ACTIVATE_CYC = TMR_W'(ACTIVATE_MS * CYC_PER_MS);
	// longest time: rounds down, exact at 40 MHz
	localparam logic [TMR_W-1:0] RESPONSE_CYC = TMR_W'(RESPONSE_MS * CYC_PER_MS);

	// ==========================================================
	// pin vector layout after synchronisation
	localparam int unsigned PIN_W = 4;
	localparam int unsigned PIN_POWER = 0;
	localparam int unsigned PIN_SAFE_A = 1;
	localparam int unsigned PIN_SAFE_B = 2;
	localparam int unsigned PIN_START = 3;

	// ==========================================================
	// reset values of the configuration
	localparam logic CFG_AUTO_RST = 1'h0;
	localparam logic CFG_INTERLOCK_RST = 1'h0;
	localparam logic CFG_SYNC_RST = 1'h0;

	// ==========================================================
	// operating states, one-hot
	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_INIT = 5'h02,
		ST_RUN_DE = 5'h04,
		ST_RUN_EN = 5'h08,
		ST_ERROR = 5'h10
	} srsm_state_t;

endpackage

// >>> design/srsm_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: pins are slow levels
// Notes: first stage is read by the second stage only

`timescale 1ns/1ps
`default_nettype none

module srsm_sync
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [srsm_pkg::PIN_W-1:0] i_pin,
	output logic [srsm_pkg::PIN_W-1:0] o_pin
);

	logic [srsm_pkg::PIN_W-1:0] meta;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta <= '0;
			o_pin <= '0;
		end
		else
		begin
			meta <= i_pin;
			o_pin <= meta;
		end
	end

endmodule

`default_nettype wire

// >>> design/srsm_timer.sv
// Purpose: saturating delay timer, done after CYCLES cycles of run
// Assumes: i_run is a same-domain level
// Notes: dropping i_run restarts the delay from zero

`timescale 1ns/1ps
`default_nettype none

module srsm_timer
#(
	parameter logic [srsm_pkg::TMR_W-1:0] CYCLES = srsm_pkg::ACTIVATE_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_run,
	output logic o_done
);

	logic [srsm_pkg::TMR_W-1:0] count;
	logic [srsm_pkg::TMR_W-1:0] next_count;
	logic next_done;

	always_comb
	begin
		next_count = '0;
		if (i_run)
		begin
			next_count = (count == CYCLES) ? count : count + 1'b1;
		end
		next_done = i_run && (next_count == CYCLES);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			count <= '0;
			o_done <= 1'b0;
		end
		else
		begin
			count <= next_count;
			o_done <= next_done;
		end
	end

	a_timer_done: assert property (@(posedge i_clk) disable iff (i_rst)
		o_done |-> (count == CYCLES))
		else $error("timer done without full count");

endmodule

`default_nettype wire

// >>> design/srsm_top.sv
// Purpose: operating-state controller of a two-channel safety relay
// Assumes: pins asynchronous; config, self-test, fault and option inputs on i_clk
// Notes: relay coil energized only in run-energized; all else is safe state
// Behaviour
// - configuration is taken only in off/configuration and ignored elsewhere.
// - every state but run-energized keeps the outputs safe; only there may they energize.
// - applying power enters initialization, whose self-tests precede any run state.
// - initialization ends only on passed self-tests, with automatic start also the switch-on delay elapsed.
// - any detected error, also during initialization, leads to the error state.
// - run-energized needs start, active safety inputs, no interlock and met synchronisation.
// - on entering run-deenergized the current safety inputs are evaluated; start counts only when pressed in run-deenergized.
// - with start inactive the device stays in run-deenergized whatever the safety inputs do.
// - start met with safety inputs inactive keeps the device in run-deenergized.
// - in run-energized, deactivated safety inputs drop the outputs and return to run-deenergized.
// - after a trip, start and safety inputs must both be activated anew.
// - with automatic start a 2500 ms switch-on delay gates leaving initialization.
// - outputs drop within 20 ms of a safety input request.
// - outputs energize 100 ms after the energize conditions are met.
// - in safe state all relay coils are off, normally-open open, normally-closed closed.

`timescale 1ns/1ps
`default_nettype none

module srsm_top
#(
	parameter logic [srsm_pkg::TMR_W-1:0] SWITCH_ON_CYC = srsm_pkg::SWITCH_ON_CYC,
	parameter logic [srsm_pkg::TMR_W-1:0] ACTIVATE_CYC = srsm_pkg::ACTIVATE_CYC,
	parameter logic [srsm_pkg::TMR_W-1:0] RESPONSE_CYC = srsm_pkg::RESPONSE_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_power_ok,
	input wire logic i_safety_a,
	input wire logic i_safety_b,
	input wire logic i_start_btn,
	input wire logic i_cfg_write,
	input wire logic i_cfg_auto_start,
	input wire logic i_cfg_interlock,
	input wire logic i_cfg_sync,
	input wire logic i_selftest_done,
	input wire logic i_selftest_pass,
	input wire logic i_fault,
	input wire logic i_interlock_free,
	input wire logic i_sync_met,
	output logic o_energize,
	output logic o_safe_state,
	output srsm_pkg::srsm_state_t o_state,
	output logic o_selftest_run,
	output logic o_cfg_auto_start,
	output logic o_cfg_interlock,
	output logic o_cfg_sync,
	output logic o_cfg_reject,
	output logic o_trip
);

	// ==========================================================
	// pin synchronisation
	logic [srsm_pkg::PIN_W-1:0] pin_s;
	logic power_s;
	logic safety_act;
	logic start_s;

	srsm_sync u_sync
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin({i_start_btn, i_safety_b, i_safety_a, i_power_ok}),
		.o_pin(pin_s)
	);

	assign power_s = pin_s[srsm_pkg::PIN_POWER];
	// both channels must be activated
	assign safety_act = pin_s[srsm_pkg::PIN_SAFE_A] && pin_s[srsm_pkg::PIN_SAFE_B];
	assign start_s = pin_s[srsm_pkg::PIN_START];

	srsm_pkg::srsm_state_t state;
	srsm_pkg::srsm_state_t next_state;

	// ==========================================================
	// configuration
	logic next_cfg_auto;
	logic next_cfg_interlock;
	logic next_cfg_sync;
	logic next_cfg_reject;

	always_comb
	begin
		next_cfg_auto = o_cfg_auto_start;
		next_cfg_interlock = o_cfg_interlock;
		next_cfg_sync = o_cfg_sync;
		next_cfg_reject = 1'b0;
		if (i_cfg_write)
		begin
			if (state == srsm_pkg::ST_OFF)
			begin
				next_cfg_auto = i_cfg_auto_start;
				next_cfg_interlock = i_cfg_interlock;
				next_cfg_sync = i_cfg_sync;
			end
			else
			begin
				next_cfg_reject = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_cfg_auto_start <= srsm_pkg::CFG_AUTO_RST;
			o_cfg_interlock <= srsm_pkg::CFG_INTERLOCK_RST;
			o_cfg_sync <= srsm_pkg::CFG_SYNC_RST;
			o_cfg_reject <= 1'b0;
		end
		else
		begin
			o_cfg_auto_start <= next_cfg_auto;
			o_cfg_interlock <= next_cfg_interlock;
			o_cfg_sync <= next_cfg_sync;
			o_cfg_reject <= next_cfg_reject;
		end
	end

	// ==========================================================
	// timers
	logic son_done;
	logic act_done;
	logic switch_on_ok;
	logic arm_ok;

	srsm_timer #(.CYCLES(SWITCH_ON_CYC)) u_switch_on
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(state == srsm_pkg::ST_INIT && o_cfg_auto_start),
		.o_done(son_done)
	);

	// manual start needs no switch-on delay
	assign switch_on_ok = !o_cfg_auto_start || son_done;

	// restarts whenever any energize condition drops, so a bouncing contact
	// cannot accumulate delay
	srsm_timer #(.CYCLES(ACTIVATE_CYC)) u_activate
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(state == srsm_pkg::ST_RUN_DE && arm_ok),
		.o_done(act_done)
	);

	// ==========================================================
	// fresh-activation tracking
	logic start_q;
	logic start_armed;
	logic safety_fresh;
	logic next_start_armed;
	logic next_safety_fresh;
	logic start_cond;

	always_comb
	begin
		next_start_armed = start_armed;
		next_safety_fresh = safety_fresh;
		// only a press seen in run-deenergized counts; a jammed button is no start
		if (state != srsm_pkg::ST_RUN_DE)
		begin
			next_start_armed = 1'b0;
		end
		else if (start_s && !start_q)
		begin
			next_start_armed = 1'b1;
		end
		if (state == srsm_pkg::ST_RUN_EN || state == srsm_pkg::ST_OFF)
		begin
			next_safety_fresh = 1'b0;
		end
		if (!safety_act || state == srsm_pkg::ST_INIT)
		begin
			next_safety_fresh = 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			start_q <= 1'b0;
			start_armed <= 1'b0;
			safety_fresh <= 1'b0;
		end
		else
		begin
			start_q <= start_s;
			start_armed <= next_start_armed;
			safety_fresh <= next_safety_fresh;
		end
	end

	assign start_cond = o_cfg_auto_start || start_armed;
	assign arm_ok = start_cond && safety_act && safety_fresh
		&& (!o_cfg_interlock || i_interlock_free)
		&& (!o_cfg_sync || i_sync_met) && !i_fault;

	// ==========================================================
	// state transitions
	logic power_up_transition;
	logic init_done_transition;
	logic energize_transition;
	logic trip_transition;
	logic fault_transition;
	logic power_down_transition;
	logic in_work;

	assign in_work = state == srsm_pkg::ST_INIT || state == srsm_pkg::ST_RUN_DE
		|| state == srsm_pkg::ST_RUN_EN;
	assign power_up_transition = state == srsm_pkg::ST_OFF && power_s;
	assign init_done_transition = state == srsm_pkg::ST_INIT && i_selftest_done
		&& i_selftest_pass && switch_on_ok;
	assign fault_transition = in_work && (i_fault || (state == srsm_pkg::ST_INIT
		&& i_selftest_done && !i_selftest_pass));
	assign energize_transition = state == srsm_pkg::ST_RUN_DE && act_done && arm_ok;
	assign trip_transition = state == srsm_pkg::ST_RUN_EN && !safety_act;
	assign power_down_transition = state != srsm_pkg::ST_OFF && !power_s;

	always_comb
	begin
		next_state = state;
		case (state)
			srsm_pkg::ST_OFF:
			begin
				if (power_up_transition)
					next_state = srsm_pkg::ST_INIT;
			end
			srsm_pkg::ST_INIT:
			begin
				if (init_done_transition)
					next_state = srsm_pkg::ST_RUN_DE;
			end
			srsm_pkg::ST_RUN_DE:
			begin
				if (energize_transition)
					next_state = srsm_pkg::ST_RUN_EN;
			end
			srsm_pkg::ST_RUN_EN:
			begin
				if (trip_transition)
					next_state = srsm_pkg::ST_RUN_DE;
			end
			srsm_pkg::ST_ERROR:
			begin
				next_state = srsm_pkg::ST_ERROR;
			end
			default:
			begin
				next_state = srsm_pkg::ST_ERROR;
			end
		endcase
		if (fault_transition)
			next_state = srsm_pkg::ST_ERROR;
		if (power_down_transition)
			next_state = srsm_pkg::ST_OFF;
	end

	// ==========================================================
	// state and outputs
	logic next_energize;

	// coil follows the next state, so a trip drops it in the same edge
	assign next_energize = next_state == srsm_pkg::ST_RUN_EN;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state <= srsm_pkg::ST_OFF;
			o_state <= srsm_pkg::ST_OFF;
			o_energize <= 1'b0;
			o_safe_state <= 1'b1;
			o_selftest_run <= 1'b0;
			o_trip <= 1'b0;
		end
		else
		begin
			state <= next_state;
			o_state <= next_state;
			o_energize <= next_energize;
			o_safe_state <= !next_energize;
			o_selftest_run <= next_state == srsm_pkg::ST_INIT;
			o_trip <= trip_transition;
		end
	end

	// ==========================================================
	// checks
	logic [srsm_pkg::TMR_W-1:0] resp_cnt;

	always_ff @(posedge i_clk)
	begin
		if (i_rst || !o_energize || safety_act)
			resp_cnt <= '0;
		else
			resp_cnt <= resp_cnt + 1'b1;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_cfg_only_off: assert property (i_cfg_write && state != srsm_pkg::ST_OFF
		|=> o_cfg_reject && $stable(o_cfg_auto_start) && $stable(o_cfg_sync))
		else $error("config taken outside off state");
	a_energize_run: assert property (o_energize |-> state == srsm_pkg::ST_RUN_EN)
		else $error("outputs energized outside run state");
	a_power_init: assert property (state == srsm_pkg::ST_OFF && power_s
		|=> state == srsm_pkg::ST_INIT && o_selftest_run)
		else $error("power-up did not enter init");
	a_init_gate: assert property (state == srsm_pkg::ST_INIT && !switch_on_ok
		|=> state != srsm_pkg::ST_RUN_DE)
		else $error("init left before switch-on delay");
	a_fault_error: assert property (in_work && i_fault && power_s
		|=> state == srsm_pkg::ST_ERROR ##1 !o_energize)
		else $error("fault did not reach error state");
	a_arm_needed: assert property (state == srsm_pkg::ST_RUN_DE && !arm_ok
		|=> state != srsm_pkg::ST_RUN_EN)
		else $error("energized without full condition");
	a_trip_drop: assert property (state == srsm_pkg::ST_RUN_EN && !safety_act && power_s
		&& !i_fault |=> state == srsm_pkg::ST_RUN_DE && !o_energize && o_trip)
		else $error("trip did not drop outputs");
	a_fresh_after_trip: assert property (o_trip |-> !start_armed ##1
		!o_energize)
		else $error("re-energized without fresh activation");
	a_response_bound: assert property (resp_cnt < RESPONSE_CYC)
		else $error("response time exceeded");
	a_error_sticky: assert property (state == srsm_pkg::ST_ERROR && power_s
		|=> state == srsm_pkg::ST_ERROR)
		else $error("error state left without power loss");
	a_safe_flag: assert property (o_safe_state == !o_energize)
		else $error("safe flag disagrees with coil");
	a_onehot: assert property ($onehot(state))
		else $error("state code not one-hot");

	c_energize: cover property (energize_transition);
	c_trip: cover property (trip_transition ##[1:20] state == srsm_pkg::ST_RUN_DE);
	c_error: cover property (state == srsm_pkg::ST_INIT ##1 state == srsm_pkg::ST_ERROR);
	c_reject: cover property (o_cfg_reject);

endmodule

`default_nettype wire

// >>> test/srsm_operator.sv
// Purpose: operator side: emergency stop contacts and start button
// Assumes: driven from the bench clock domain
// Notes: channel b follows channel a one cycle late, as real contacts do

`timescale 1ns/1ps
`default_nettype none

module srsm_operator
(
	input wire logic i_clk,
	input wire logic i_estop_out,
	input wire logic i_press,
	output logic o_safety_a = 1'h0,
	output logic o_safety_b = 1'h0,
	output logic o_start_btn = 1'h0
);
	// ==========================================================
	// contacts and button
	// re-arming needs a fresh press and restored contacts
	always_ff @(posedge i_clk)
	begin
		o_safety_a <= i_estop_out;
		o_safety_b <= o_safety_a;
		o_start_btn <= i_press;
	end
endmodule

`default_nettype wire

// >>> test/srsm_top_tb_top.sv
// Purpose: self-checking bench of the safety relay state machine
// Assumes: shortened delays of 20, 10 and 50 cycles
// Notes: state changes are checked against a queue of expected states

`timescale 1ns/1ps
`default_nettype none

module srsm_top_tb_top;
	logic i_clk = 1'h0;
	logic i_rst = 1'h1;
	logic power = 1'h0, estop_out = 1'h0, press = 1'h0, cfg_write = 1'h0;
	logic cfg_auto = 1'h0, cfg_il = 1'h0, cfg_sync = 1'h0, st_done = 1'h0;
	logic st_pass = 1'h0, fault = 1'h0, il_free = 1'h1, sync_met = 1'h1;
	logic safety_a, safety_b, start_btn, o_energize, o_safe_state, o_selftest_run;
	logic o_cfg_auto_start, o_cfg_interlock, o_cfg_sync, o_cfg_reject, o_trip;
	srsm_pkg::srsm_state_t o_state, last_st = srsm_pkg::ST_OFF;
	srsm_pkg::srsm_state_t exp_q[$];
	int n_mismatch = 0, compares = 0, k = 0;
	integer seed = 32'h14B3;

	always #12.5 i_clk = ~i_clk;

	srsm_operator i_srsm_operator (.i_clk(i_clk), .i_estop_out(estop_out), .i_press(press),
		.o_safety_a(safety_a), .o_safety_b(safety_b), .o_start_btn(start_btn));

	srsm_top #(.SWITCH_ON_CYC(27'h14), .ACTIVATE_CYC(27'hA), .RESPONSE_CYC(27'h32)) i_srsm_top (
		.i_clk(i_clk), .i_rst(i_rst), .i_power_ok(power), .i_safety_a(safety_a),
		.i_safety_b(safety_b), .i_start_btn(start_btn), .i_cfg_write(cfg_write),
		.i_cfg_auto_start(cfg_auto), .i_cfg_interlock(cfg_il), .i_cfg_sync(cfg_sync),
		.i_selftest_done(st_done), .i_selftest_pass(st_pass), .i_fault(fault),
		.i_interlock_free(il_free), .i_sync_met(sync_met), .o_energize(o_energize),
		.o_safe_state(o_safe_state), .o_state(o_state), .o_selftest_run(o_selftest_run),
		.o_cfg_auto_start(o_cfg_auto_start), .o_cfg_interlock(o_cfg_interlock),
		.o_cfg_sync(o_cfg_sync), .o_cfg_reject(o_cfg_reject), .o_trip(o_trip));

	// ==========================================================
	// compare and report
	task automatic check_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_st(input srsm_pkg::srsm_state_t exp, input srsm_pkg::srsm_state_t got);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] state expected %h seen %h", exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// note the next state, then wait for it; k returns the cycles waited
	task automatic expect_st(input srsm_pkg::srsm_state_t exp, input int max);
		exp_q.push_back(exp);
		k = 0;
		while (k < max && o_state !== exp)
		begin
			@(posedge i_clk);
			#1;
			k++;
		end
		// let the watcher take its note before anyone looks at the queue
		#1;
	endtask

	task automatic test_done(input string name);
		check_bit("queue empty", 1'h1, exp_q.size() == 0);
		$display("test %s done", name);
	endtask

	// ==========================================================
	// output watcher: any state change must be the oldest note
	always @(posedge i_clk)
	begin
		#1;
		if (i_rst)
			last_st = o_state;
		else if (o_state !== last_st)
		begin
			if (exp_q.size() == 0)
				check_st(last_st, o_state);
			else
				check_st(exp_q.pop_front(), o_state);
			check_bit("energize", o_state === srsm_pkg::ST_RUN_EN, o_energize);
			check_bit("safe", o_state !== srsm_pkg::ST_RUN_EN, o_safe_state);
			if (last_st === srsm_pkg::ST_RUN_EN && o_state === srsm_pkg::ST_RUN_DE)
				check_bit("trip", 1'h1, o_trip);
			last_st = o_state;
		end
	end

	initial
	begin
		#(25 * 5000);
		n_mismatch++;
		report_and_stop();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		tick(2);
		i_rst <= 1'h0;
		cfg_write <= 1'h1;
		cfg_il <= 1'($random(seed));
		cfg_sync <= 1'($random(seed));
		tick(1);
		cfg_write <= 1'h0;
		tick(1);
		#1;
		check_bit("cfg il", cfg_il, o_cfg_interlock);
		check_bit("cfg sync", cfg_sync, o_cfg_sync);
		test_done("config");
		tick(1);
		power <= 1'h1;
		st_done <= 1'h1;
		st_pass <= 1'h1;
		expect_st(srsm_pkg::ST_INIT, 10);
		check_bit("selftest run", 1'h1, o_selftest_run);
		expect_st(srsm_pkg::ST_RUN_DE, 5);
		tick(1);
		cfg_write <= 1'h1;
		cfg_auto <= 1'h1;
		tick(1);
		cfg_write <= 1'h0;
		estop_out <= 1'h1;
		#1;
		check_bit("reject", 1'h1, o_cfg_reject);
		check_bit("cfg auto", 1'h0, o_cfg_auto_start);
		tick(30);
		#1;
		check_st(srsm_pkg::ST_RUN_DE, o_state);
		test_done("no start");
		tick(1);
		estop_out <= 1'h0;
		press <= 1'h1;
		tick(5);
		press <= 1'h0;
		tick(30);
		#1;
		check_st(srsm_pkg::ST_RUN_DE, o_state);
		tick(1);
		estop_out <= 1'h1;
		tick(5);
		press <= 1'h1;
		expect_st(srsm_pkg::ST_RUN_EN, 40);
		check_bit("activation delay", 1'h1, k >= 10);
		test_done("energize");
		tick(1);
		press <= 1'h0;
		estop_out <= 1'h0;
		expect_st(srsm_pkg::ST_RUN_DE, 6);
		tick(1);
		estop_out <= 1'h1;
		tick(30);
		#1;
		check_st(srsm_pkg::ST_RUN_DE, o_state);
		tick(1);
		press <= 1'h1;
		expect_st(srsm_pkg::ST_RUN_EN, 40);
		test_done("trip and rearm");
		tick(1);
		press <= 1'h0;
		fault <= 1'h1;
		expect_st(srsm_pkg::ST_ERROR, 3);
		tick(1);
		fault <= 1'h0;
		tick(10);
		#1;
		check_st(srsm_pkg::ST_ERROR, o_state);
		tick(1);
		power <= 1'h0;
		expect_st(srsm_pkg::ST_OFF, 5);
		test_done("fault");
		tick(1);
		cfg_write <= 1'h1;
		cfg_il <= 1'h1;
		cfg_sync <= 1'h1;
		il_free <= 1'h0;
		sync_met <= 1'h0;
		tick(1);
		cfg_write <= 1'h0;
		power <= 1'h1;
		expect_st(srsm_pkg::ST_INIT, 10);
		check_bit("cfg auto", 1'h1, o_cfg_auto_start);
		check_bit("cfg il", 1'h1, o_cfg_interlock);
		expect_st(srsm_pkg::ST_RUN_DE, 40);
		check_bit("switch-on delay", 1'h1, k >= 19);
		tick(30);
		#1;
		check_st(srsm_pkg::ST_RUN_DE, o_state);
		tick(1);
		il_free <= 1'h1;
		tick(20);
		#1;
		check_st(srsm_pkg::ST_RUN_DE, o_state);
		tick(1);
		sync_met <= 1'h1;
		expect_st(srsm_pkg::ST_RUN_EN, 40);
		tick(1);
		power <= 1'h0;
		expect_st(srsm_pkg::ST_OFF, 5);
		test_done("auto start");
		tick(1);
		st_pass <= 1'h0;
		power <= 1'h1;
		expect_st(srsm_pkg::ST_INIT, 10);
		expect_st(srsm_pkg::ST_ERROR, 5);
		tick(1);
		power <= 1'h0;
		expect_st(srsm_pkg::ST_OFF, 5);
		test_done("selftest fail");
		report_and_stop();
	end
endmodule

`default_nettype wire
